// ---- hw/afpl_chan.sv ----
// one temperature channel: start temperature and span to a duty in slots
`timescale 1ns/100ps
module afpl_chan
    import afpl_pkg::*;
(
    input  wire logic [7:0] temp,
    input  wire logic [4:0] start_code,
    input  wire logic [2:0] span_code,
    input  wire logic [3:0] min_code,
    output logic      [7:0] duty
);
    logic [7:0]  start_deg;
    logic [7:0]  above;
    logic [5:0]  per_deg;
    logic [14:0] raw;

    // ten codes per span is 160 slots per span, so slots per degree is 160/span
    always_comb begin
        start_deg = {1'b0, start_code, 2'b00};
        above     = temp - start_deg;
        unique case (span_code)
            3'h0:    per_deg = 6'h20;
            3'h1:    per_deg = 6'h10;
            3'h2:    per_deg = 6'h08;
            3'h3:    per_deg = 6'h04;
            default: per_deg = 6'h02;
        endcase
        raw = 15'(min_code * SLOTS_PER_CODE) + 15'(above * per_deg);
        if (temp < start_deg) begin
            duty = 8'h00;
        end else if (raw > 15'(PWM_SLOTS)) begin
            duty = PWM_SLOTS;
        end else begin
            duty = raw[7:0];
        end
    end
endmodule

// ---- hw/afpl_pwm.sv ----
// 240-slot pwm generator; duty is taken at each period start
`timescale 1ns/100ps
module afpl_pwm
    import afpl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [16:0] slot_len,
    input  wire logic [7:0]  duty,
    output logic             pwm_out
);
    typedef struct packed {
        logic [16:0] div;
        logic [7:0]  slot;
        logic [7:0]  duty;
        logic        out;
    } afpl_pwm_t;

    afpl_pwm_t p_r;
    afpl_pwm_t p_nxt;

    // latching duty per period avoids runt pulses when the loop changes it
    always_comb begin
        p_nxt = p_r;
        if (p_r.div >= slot_len - 17'h00001) begin
            p_nxt.div = 17'h00000;
            if (p_r.slot == PWM_SLOTS - 8'h01) begin
                p_nxt.slot = 8'h00;
                p_nxt.duty = duty;
            end else begin
                p_nxt.slot = p_r.slot + 8'h01;
            end
        end else begin
            p_nxt.div = p_r.div + 17'h00001;
        end
        p_nxt.out = (p_nxt.slot < p_nxt.duty);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_r <= '0;
        end else begin
            p_r <= p_nxt;
        end
    end

    assign pwm_out = p_r.out;
endmodule

// ---- hw/afpl_top.sv ----
// temperature driven fan pwm loop with filtered ramp mode and apb registers
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module afpl_top
    import afpl_pkg::*;
#(
    parameter int UPD_TICK  = UPD_TICK_CYC,
    parameter int SPIN_TICK = SPIN_TICK_CYC,
    parameter int SLOT_KHZ  = CLK_KHZ
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  local_temp,
    input  wire logic [7:0]  remote_temp,
    output logic             pwm_out
);
    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  fch;
        logic [7:0]  fsp;
        logic [7:0]  flt;
        logic [7:0]  lthr;
        logic [7:0]  rthr;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [31:0] upd_div;
        logic [7:0]  upd_cnt;
        logic        upd;
        logic [31:0] spin_div;
        logic        spin_tick;
        logic [5:0]  spin_left;
        logic        spinning;
        logic [7:0]  duty;
    } afpl_state_t;

    afpl_state_t s_r;
    afpl_state_t s_nxt;

    logic [7:0]  local_duty;
    logic [7:0]  remote_duty;
    logic [7:0]  target;
    logic [7:0]  stepped;
    logic [7:0]  new_duty;
    logic [7:0]  drive_duty;
    logic [16:0] slot_len;
    logic [5:0]  idx;
    logic        hit;
    logic [31:0] rdata;

    localparam logic [16:0] SLOT_TAB [8] = '{
        slot_cyc(SLOT_KHZ, 3'h0), slot_cyc(SLOT_KHZ, 3'h1),
        slot_cyc(SLOT_KHZ, 3'h2), slot_cyc(SLOT_KHZ, 3'h3),
        slot_cyc(SLOT_KHZ, 3'h4), slot_cyc(SLOT_KHZ, 3'h5),
        slot_cyc(SLOT_KHZ, 3'h6), slot_cyc(SLOT_KHZ, 3'h7)
    };
    localparam logic [31:0] UPD_LAST  = 32'(UPD_TICK - 1);
    localparam logic [31:0] SPIN_LAST = 32'(SPIN_TICK - 1);

    // move cur toward tgt by step without passing it
    function automatic logic [7:0] ramp(input logic [7:0] cur,
                                        input logic [7:0] tgt,
                                        input logic [1:0] code);
        logic [7:0] step;
        step = 8'h01 << code;
        if (tgt > cur) begin
            ramp = (tgt - cur < step) ? tgt : cur + step;
        end else if (tgt < cur) begin
            ramp = (cur - tgt < step) ? tgt : cur - step;
        end else begin
            ramp = cur;
        end
    endfunction

    afpl_chan u_local (
        .temp       (local_temp),
        .start_code (s_r.lthr[THR_START_LSB +: 5]),
        .span_code  (s_r.lthr[THR_SPAN_LSB +: 3]),
        .min_code   (s_r.fsp[FSP_MIN_LSB +: 4]),
        .duty       (local_duty)
    );

    afpl_chan u_remote (
        .temp       (remote_temp),
        .start_code (s_r.rthr[THR_START_LSB +: 5]),
        .span_code  (s_r.rthr[THR_SPAN_LSB +: 3]),
        .min_code   (s_r.fsp[FSP_MIN_LSB +: 4]),
        .duty       (remote_duty)
    );

    always_comb begin
        // channel selection; undefined codes fall back to the remote loop
        if (s_r.cfg[CFG_CHAN_LSB +: 2] == CHAN_MAX) begin
            target = (local_duty > remote_duty) ? local_duty : remote_duty;
        end else begin
            target = remote_duty;
        end
        stepped  = ramp(s_r.duty, target, s_r.flt[FLT_RAMP_LSB +: 2]);
        new_duty = s_r.flt[FLT_EN_BIT] ? stepped : target;
        drive_duty = s_r.spinning ? PWM_SLOTS : s_r.duty;
        slot_len = SLOT_TAB[s_r.fch[FCH_FREQ_LSB +: 3]];
        idx = paddr[7:2];
        hit = (paddr[1:0] == 2'h0) && ((idx == IDX_CFG) || (idx == IDX_FCH) ||
              (idx == IDX_FSP) || (idx == IDX_FLT) || (idx == IDX_LTHR) ||
              (idx == IDX_RTHR) || (idx == IDX_STAT));
        rdata = 32'h00000000;
        unique case (idx)
            IDX_CFG:  rdata[7:0] = s_r.cfg;
            IDX_FCH:  rdata[7:0] = s_r.fch;
            IDX_FSP:  rdata[7:0] = s_r.fsp;
            IDX_FLT:  rdata[7:0] = s_r.flt;
            IDX_LTHR: rdata[7:0] = s_r.lthr;
            IDX_RTHR: rdata[7:0] = s_r.rthr;
            IDX_STAT: begin
                rdata[7:0]             = s_r.duty;
                rdata[STAT_SPIN_BIT]   = s_r.spinning;
                rdata[STAT_AUTO_BIT]   = s_r.cfg[CFG_AUTO_BIT];
            end
            default:  rdata = 32'h00000000;
        endcase
    end

    always_comb begin
        s_nxt           = s_r;
        s_nxt.upd       = 1'b0;
        s_nxt.spin_tick = 1'b0;
        s_nxt.pready    = 1'b0;
        s_nxt.pslverr   = 1'b0;

        // temperature update timer: 125 ms ticks, counted per sample rate code
        if (s_r.upd_div >= UPD_LAST) begin
            s_nxt.upd_div = 32'h00000000;
            if (s_r.upd_cnt >= upd_ticks(s_r.flt[FLT_RATE_LSB +: 3]) - 8'h01) begin
                s_nxt.upd_cnt = 8'h00;
                s_nxt.upd     = 1'b1;
            end else begin
                s_nxt.upd_cnt = s_r.upd_cnt + 8'h01;
            end
        end else begin
            s_nxt.upd_div = s_r.upd_div + 32'h00000001;
        end

        // free running 200 ms unit; first unit of a spin-up may be short by up to one unit
        if (s_r.spin_div >= SPIN_LAST) begin
            s_nxt.spin_div  = 32'h00000000;
            s_nxt.spin_tick = 1'b1;
        end else begin
            s_nxt.spin_div = s_r.spin_div + 32'h00000001;
        end

        if (s_r.spinning && s_r.spin_tick) begin
            if (s_r.spin_left <= 6'h01) begin
                s_nxt.spinning  = 1'b0;
                s_nxt.spin_left = 6'h00;
            end else begin
                s_nxt.spin_left = s_r.spin_left - 6'h01;
            end
        end

        if (s_r.cfg[CFG_AUTO_BIT]) begin
            if (s_r.upd) begin
                s_nxt.duty = new_duty;
                if (s_r.duty == 8'h00 && new_duty != 8'h00 &&
                    !s_r.flt[FLT_SPINDIS_BIT]) begin
                    s_nxt.spinning  = 1'b1;
                    s_nxt.spin_left = spin_units(s_r.fch[FCH_SPIN_LSB +: 3]);
                end
            end
        end else begin
            // software ownership: duty follows the programmed code directly
            s_nxt.duty     = 8'(s_r.fsp[FSP_MIN_LSB +: 4] * SLOTS_PER_CODE);
            s_nxt.spinning = 1'b0;
        end

        // apb: setup cycle decodes, access phase answers with pready
        if (psel && !penable) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !hit;
            // a refused misaligned read must not leak the register that its index bits select
            s_nxt.prdata  = (pwrite || !hit) ? 32'h00000000 : rdata;
        end

        if (psel && penable && s_r.pready && pwrite && !s_r.pslverr && pstrb[0]) begin
            unique case (idx)
                IDX_CFG:  s_nxt.cfg  = pwdata[7:0];
                IDX_FCH:  s_nxt.fch  = pwdata[7:0];
                IDX_FSP:  s_nxt.fsp  = pwdata[7:0];
                IDX_FLT:  s_nxt.flt  = pwdata[7:0] & FLT_WR_MASK;
                IDX_LTHR: s_nxt.lthr = pwdata[7:0];
                IDX_RTHR: s_nxt.rthr = pwdata[7:0];
                default:  s_nxt.cfg  = s_r.cfg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r      <= '0;
            s_r.cfg  <= CFG_RST;
            s_r.fch  <= FCH_RST;
            s_r.fsp  <= FSP_RST;
            s_r.flt  <= FLT_RST;
            s_r.lthr <= LTHR_RST;
            s_r.rthr <= RTHR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    afpl_pwm u_pwm (
        .pclk     (pclk),
        .presetn  (presetn),
        .slot_len (slot_len),
        .duty     (drive_duty),
        .pwm_out  (pwm_out)
    );

    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = s_r.pslverr;
endmodule

// ---- pkg/afpl_pkg.sv ----
// shared constants, register map and helper functions for the auto fan pwm loop
package afpl_pkg;

    localparam int          CLK_HZ           = 125_000_000;
    localparam int          CLK_KHZ          = CLK_HZ / 1000;

    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_CFG          = 6'h00;
    localparam logic [5:0]  IDX_FCH          = 6'h20;
    localparam logic [5:0]  IDX_FSP          = 6'h22;
    localparam logic [5:0]  IDX_FLT          = 6'h23;
    localparam logic [5:0]  IDX_LTHR         = 6'h24;
    localparam logic [5:0]  IDX_RTHR         = 6'h25;
    localparam logic [5:0]  IDX_STAT         = 6'h26;

    // field positions
    localparam int          CFG_AUTO_BIT     = 7;
    localparam int          CFG_CHAN_LSB     = 5;
    localparam int          FCH_SPIN_LSB     = 0;
    localparam int          FCH_FREQ_LSB     = 3;
    localparam int          FCH_RANGE_LSB    = 6;
    localparam int          FSP_MIN_LSB      = 0;
    localparam int          FLT_EN_BIT       = 0;
    localparam int          FLT_RATE_LSB     = 2;
    localparam int          FLT_RAMP_LSB     = 5;
    localparam int          FLT_SPINDIS_BIT  = 7;
    localparam int          THR_SPAN_LSB     = 0;
    localparam int          THR_START_LSB    = 3;
    localparam int          STAT_SPIN_BIT    = 8;
    localparam int          STAT_AUTO_BIT    = 9;

    // reset values
    localparam logic [7:0]  CFG_RST          = 8'h80;
    localparam logic [7:0]  FCH_RST          = 8'h1d;
    localparam logic [7:0]  FSP_RST          = 8'h05;
    localparam logic [7:0]  FLT_RST          = 8'h10;
    localparam logic [7:0]  LTHR_RST         = 8'h40;
    localparam logic [7:0]  RTHR_RST         = 8'h40;
    localparam logic [7:0]  FLT_WR_MASK      = 8'hfd;

    // channel select codes
    localparam logic [1:0]  CHAN_REMOTE      = 2'h0;
    localparam logic [1:0]  CHAN_MAX         = 2'h3;

    // duty scale
    localparam logic [7:0]  PWM_SLOTS        = 8'hf0;
    localparam logic [7:0]  SLOTS_PER_CODE   = 8'h10;

    // timing: update tick is the 8-per-second period, spin tick the 200 ms unit
    localparam int          UPD_TICK_MS      = 125;
    localparam int          SPIN_TICK_MS     = 200;
    localparam int          UPD_TICK_CYC     = CLK_KHZ * UPD_TICK_MS;
    localparam int          SPIN_TICK_CYC    = CLK_KHZ * SPIN_TICK_MS;

    // pwm frequency in milli-hertz per code
    function automatic longint pwm_freq_mhz(input logic [2:0] code);
        unique case (code)
            3'h0: pwm_freq_mhz = 11700;
            3'h1: pwm_freq_mhz = 15600;
            3'h2: pwm_freq_mhz = 23400;
            3'h3: pwm_freq_mhz = 31250;
            3'h4: pwm_freq_mhz = 37500;
            3'h5: pwm_freq_mhz = 46900;
            3'h6: pwm_freq_mhz = 62500;
            3'h7: pwm_freq_mhz = 93500;
        endcase
    endfunction

    // clock cycles per slot, rounded down, never below one
    function automatic logic [16:0] slot_cyc(input longint clk_khz, input logic [2:0] code);
        longint c;
        c = (clk_khz * 1_000_000) / (240 * pwm_freq_mhz(code));
        slot_cyc = (c < 1) ? 17'h00001 : c[16:0];
    endfunction

    // spin-up time in 200 ms units
    function automatic logic [5:0] spin_units(input logic [2:0] code);
        unique case (code)
            3'h0: spin_units = 6'h01;
            3'h1: spin_units = 6'h02;
            3'h2: spin_units = 6'h03;
            3'h3: spin_units = 6'h04;
            3'h4: spin_units = 6'h05;
            3'h5: spin_units = 6'h0a;
            3'h6: spin_units = 6'h14;
            3'h7: spin_units = 6'h28;
        endcase
    endfunction

    // update period in 125 ms ticks: 128 down to 1
    function automatic logic [7:0] upd_ticks(input logic [2:0] code);
        upd_ticks = 8'h80 >> code;
    endfunction

endpackage

// ---- tb/afpl_fan_model.sv ----
// fan model: measures high time and period of the drive it receives
`timescale 1ns/100ps
module afpl_fan_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pwm_in,
    output logic      [31:0] hi_cyc,
    output logic      [31:0] per_cyc
);
    logic        prev_r;
    logic [31:0] hc_r;
    logic [31:0] pc_r;

    // a constant level has no edges, so the last measurement stays
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r  <= 1'b0;
            hc_r    <= 32'h0;
            pc_r    <= 32'h0;
            hi_cyc  <= 32'h0;
            per_cyc <= 32'h0;
        end else begin
            prev_r <= pwm_in;
            if (pwm_in && !prev_r) begin
                per_cyc <= pc_r;
                pc_r    <= 32'h1;
            end else begin
                pc_r <= pc_r + 32'h1;
            end
            if (!pwm_in && prev_r) begin
                hi_cyc <= hc_r;
                hc_r   <= 32'h0;
            end else if (pwm_in) begin
                hc_r <= hc_r + 32'h1;
            end
        end
    end
endmodule

// ---- tb/afpl_top_chk.sv ----
// register port checker for the auto fan pwm loop
`timescale 1ns/100ps
module afpl_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("setup cycle got no answer");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    upper_zero_a: assert property (pready |-> prdata[31:10] == 22'h0)
        else $error("read data upper bits set");
    misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    mapped_ok_a: assert property (psel && !penable
        && paddr inside {8'h00, 8'h80, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98} |=> !pslverr)
        else $error("mapped register refused");
    flt_bit1_a: assert property (pready && !pwrite && paddr == 8'h8c |-> !prdata[1])
        else $error("filter unused bit reads one");
endmodule

bind afpl_top afpl_top_chk u_afpl_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

// ---- tb/tb_afpl_top.sv ----
// self-checking bench for the auto fan pwm loop
`timescale 1ns/100ps
module tb_afpl_top
    import afpl_pkg::*;
;
    localparam logic [7:0] CF = {IDX_CFG, 2'b00};
    localparam logic [7:0] FC = {IDX_FCH, 2'b00};
    localparam logic [7:0] FS = {IDX_FSP, 2'b00};
    localparam logic [7:0] FL = {IDX_FLT, 2'b00};
    localparam logic [7:0] LT = {IDX_LTHR, 2'b00};
    localparam logic [7:0] RT = {IDX_RTHR, 2'b00};
    localparam logic [7:0] ST = {IDX_STAT, 2'b00};
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [3:0]  pstrb       = 4'hf;
    logic [7:0]  local_temp  = 8'h00;
    logic [7:0]  remote_temp = 8'h00;
    logic [31:0] prdata, rq, hi_cyc, per_cyc;
    logic        pready, pslverr, pwm_out, re;
    int          n_fail      = 0;
    int          checks      = 0;
    logic [7:0]  ra [7]      = '{CF, FC, FS, FL, LT, RT, ST};
    logic [31:0] rv [7]      = '{CFG_RST, FCH_RST, FSP_RST, FLT_RST, LTHR_RST, RTHR_RST, 32'h200};

    always #4 pclk = ~pclk;

    afpl_top #(.UPD_TICK(10), .SPIN_TICK(20), .SLOT_KHZ(240)) u_afpl_top (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_temp(local_temp), .remote_temp(remote_temp), .pwm_out(pwm_out));
    afpl_fan_model u_afpl_fan_model (.pclk(pclk), .presetn(presetn), .pwm_in(pwm_out),
        .hi_cyc(hi_cyc), .per_cyc(per_cyc));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        // answer is taken at the edge that samples pready high; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq      = prdata;
        re      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // loop parameters go in while software owns the fan, mode bit last
    task automatic setup(input int cf, input int fl, input int fs, input int lt, input int rt);
        apb(1, CF, 0);
        apb(1, FL, fl);
        apb(1, FS, fs);
        apb(1, LT, lt);
        apb(1, RT, rt);
        apb(1, CF, cf);
    endtask

    function automatic int exp_chan(int t, int st, int sp, int mn);
        int v;
        if (t < st * 4) return 0;
        v = mn * 16 + (t - st * 4) * (160 / ((sp >= 4) ? 80 : (5 << sp)));
        return (v > 240) ? 240 : v;
    endfunction

    task automatic ramp(input int tgt, input int step);
        int prev, cur, mx, n, d;
        mx = 0;
        n  = 0;
        apb(0, ST, 0);
        prev = rq[7:0];
        cur  = prev;
        while (cur != tgt && n < 1500) begin
            apb(0, ST, 0);
            cur = rq[7:0];
            d   = (cur > prev) ? cur - prev : prev - cur;
            if (d > mx) mx = d;
            prev = cur;
            n++;
        end
        chk(mx, step);
        chk(n inside {[630:680]}, 1'b1);
        chk(cur, tgt);
    endtask

    task automatic results;
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #640000;
        n_fail++;
        results;
    end

    initial begin
        int st, sp, mn, lt, rt, ls, lp, c, s, v, cf;
        void'($urandom(32'ha001));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            apb(0, ra[i], 0);
            chk(rq, rv[i]);
        end
        for (int i = 0; i < 6; i++) begin
            v = $urandom_range(255, 0);
            apb(1, ra[i], v);
            if (i == 2) mn = v;
            apb(0, ra[i], 0);
            chk(rq, (i == 3) ? v & FLT_WR_MASK : v);
        end
        @(posedge pclk);
        pstrb <= 4'h0;
        apb(1, FS, 8'h0c);
        pstrb <= 4'hf;
        apb(0, FS, 0);
        chk(rq, mn);
        apb(0, 8'hfc, 0);
        chk(rq, 32'h0);
        chk(re, 1'b1);
        apb(1, 8'h89, 1);
        chk(re, 1'b1);
        apb(0, 8'h81, 0);
        chk(rq, 32'h0);
        chk(re, 1'b1);
        apb(1, CF, 0);
        for (c = 0; c < 16; c++) begin
            apb(1, FS, c);
            apb(0, ST, 0);
            chk(rq, c * 16);
        end
        apb(1, FS, 5);
        for (c = 5; c < 8; c++) begin
            s = (c == 5) ? 21 : (c == 6) ? 16 : 10;
            apb(1, FC, c << 3);
            repeat (4 * 240 * s) @(posedge pclk);
            chk(hi_cyc, 80 * s);
            chk(per_cyc, 240 * s);
        end
        for (int i = 0; i < 14; i++) begin
            st = $urandom_range(31, 1);
            sp = $urandom_range(4, 0);
            mn = $urandom_range(15, 0);
            ls = $urandom_range(31, 0);
            lp = $urandom_range(4, 0);
            lt = $urandom_range(255, 0);
            rt = (i == 0) ? st * 4 : (i == 1) ? st * 4 - 1 : $urandom_range(255, 0);
            cf = (i > 1 && i % 2 == 1) ? 8'he0 : (i % 4 == 2) ? 8'ha0 : 8'h80;
            @(posedge pclk);
            remote_temp <= 8'(rt);
            local_temp  <= 8'(lt);
            setup(cf, 8'h9c, mn, ls * 8 + lp, st * 8 + sp);
            repeat (25) @(posedge pclk);
            apb(0, ST, 0);
            c = exp_chan(rt, st, sp, mn);
            v = exp_chan(lt, ls, lp, mn);
            if (cf == 8'he0 && v > c) c = v;
            chk(rq, 32'h200 | c);
        end
        // spin-up from a stopped fan, two 200 ms units
        @(posedge pclk);
        remote_temp <= 8'd40;
        apb(1, FC, 8'h39);
        setup(8'h80, 8'h1c, 0, 0, 8'h04);
        c = 0;
        for (int k = 0; k < 40; k++) begin
            apb(0, ST, 0);
            if (rq[8] === 1'b1) c++;
        end
        chk(c inside {[6:14]}, 1'b1);
        chk(rq, 32'h250);
        for (int r = 0; r < 4; r++) begin
            @(posedge pclk);
            remote_temp <= 8'd0;
            setup(8'h80, 8'h81 | (r << 5) | ((7 - r) << 2), 0, 0, 8'h04);
            @(posedge pclk);
            remote_temp <= 8'd100;
            ramp(200, 1 << r);
            @(posedge pclk);
            remote_temp <= 8'd0;
            ramp(0, 1 << r);
        end
        results;
    end
endmodule
